// >>> hw/pdmc_power_controller.sv
// Purpose: power mode sequencer for the six power domains
// Assumes: all inputs synchronous to clock; cpuWfi is a one-cycle pulse
// Notes: voltage outputs are 1 for 1.1V and 0 for 0.9V
`timescale 1ns/1ps
`default_nettype none

module pdmc_power_controller #(
  parameter int ANALOG_COUNT = 8,
  parameter int SETTLE_COUNT = pdmc_pkg::SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEnable,
  input wire logic regWrite,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic cpuWfi,
  input wire logic deep_power_down_select,
  input wire logic interruptPending,
  input wire logic external_wake_interrupt,
  input wire logic radio_low_power_counter,
  input wire logic rtcWakeInterrupt,
  input wire logic lowSpeedRunRequest,
  input wire logic perPowerRequest,
  input wire logic perVoltHighRequest,
  input wire logic radioPowerRequest,
  input wire logic radioVoltHighRequest,
  input wire logic [pdmc_pkg::SRAM_BLOCKS-1:0] sramPowerRequest,
  input wire logic [pdmc_pkg::SRAM_BLOCKS-1:0] sramRetainRequest,
  input wire logic [pdmc_pkg::TRIM_WIDTH-1:0] sramRetentionTrim,
  input wire logic [ANALOG_COUNT-1:0] analogPowerRequest,
  input wire logic [31:0] memAddr,
  output logic [pdmc_pkg::SRAM_BLOCKS-1:0] sramBlockSelect,
  output logic awoPowerOn,
  output logic awoSlowClock,
  output logic cpuPowerOn,
  output logic cpuVoltHigh,
  output logic cpuClockGated,
  output logic cpuResetHold,
  output logic perPowerOn,
  output logic perVoltHigh,
  output logic radioPowerOn,
  output logic radioVoltHigh,
  output logic [pdmc_pkg::SRAM_BLOCKS-1:0] sramPowerOn,
  output logic [pdmc_pkg::SRAM_BLOCKS-1:0] sramRetain,
  output logic [pdmc_pkg::TRIM_WIDTH-1:0] sramSupplyTrim,
  output logic [ANALOG_COUNT-1:0] analogPowerOn,
  output logic [2:0] powerMode,
  output logic sequenceBusy
);

  if (ANALOG_COUNT < 1) begin : g_bad_analog
    $error("ANALOG_COUNT must be at least 1");
  end
  if (SETTLE_COUNT < 1 || SETTLE_COUNT >= (1 << 16)) begin : g_bad_settle
    $error("SETTLE_COUNT must lie in 1..65535");
  end

  localparam int CW = 16;
  localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_COUNT);
  localparam int NB = pdmc_pkg::SRAM_BLOCKS;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [NB-1:0] sramDecode(input logic [31:0] addr);
    logic [31:0] offset;
    logic [NB-1:0] hit;
    offset = addr - pdmc_pkg::SRAM_BASE;
    hit = '0;
    for (int i = 0; i < NB; i++) begin
      if (addr >= pdmc_pkg::SRAM_BASE && addr <= pdmc_pkg::SRAM_END &&
          (offset >> pdmc_pkg::SRAM_BLOCK_SHIFT) == 32'(i)) begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction : sramDecode

  function automatic logic isRunning(input pdmc_pkg::pdmc_state_e s);
    return s == pdmc_pkg::ST_ACTIVE || s == pdmc_pkg::ST_ACTIVE_LOW ||
           s == pdmc_pkg::ST_SLEEP || s == pdmc_pkg::ST_SLEEP_LOW;
  endfunction : isRunning

  //////////////////////////////////////////////////////////////////////////////
  // state

  pdmc_pkg::pdmc_state_e state_q, state_d;
  logic [CW-1:0] settle_q, settle_d;
  logic deepTarget_q, deepTarget_d;
  logic wakeVolt_q, wakeVolt_d;
  logic [31:0] regRdata_q, regRdata_d;
  logic [NB-1:0] sramSel_q, sramSel_d;
  logic awoOn_q;
  logic slowClock_q, slowClock_d;
  logic cpuOn_q, cpuOn_d;
  logic cpuHigh_q, cpuHigh_d;
  logic gated_q, gated_d;
  logic hold_q, hold_d;
  logic perOn_q, perOn_d;
  logic perHigh_q, perHigh_d;
  logic radioOn_q, radioOn_d;
  logic radioHigh_q, radioHigh_d;
  logic [NB-1:0] sramOn_q, sramOn_d;
  logic [NB-1:0] retain_q, retain_d;
  logic [pdmc_pkg::TRIM_WIDTH-1:0] trim_q, trim_d;
  logic [ANALOG_COUNT-1:0] analogOn_q, analogOn_d;
  logic [2:0] mode_q, mode_d;
  logic busy_q, busy_d;

  //////////////////////////////////////////////////////////////////////////////
  // decode

  wire logic wakeAny = external_wake_interrupt | radio_low_power_counter | rtcWakeInterrupt;
  wire logic retainAny = |(sramOn_q & sramRetainRequest);
  wire logic settleDone = settle_q == '0;
  wire logic regHit = regAddr == pdmc_pkg::WAKE_VOLT_ADDR;
  wire logic [NB-1:0] sramWanted = (sramPowerRequest == '0) ? pdmc_pkg::SRAM_FIRST_ONLY : sramPowerRequest;
  wire logic runNext = isRunning(state_d);
  wire logic enterDownCore = state_d == pdmc_pkg::ST_DOWN_CORE && state_q == pdmc_pkg::ST_DOWN_PERIPH;
  wire logic keepRetain = state_d == pdmc_pkg::ST_DOWN_CORE || state_d == pdmc_pkg::ST_EXT_SLEEP;
  wire logic coreDown = state_d == pdmc_pkg::ST_DOWN_CORE || state_d == pdmc_pkg::ST_EXT_SLEEP ||
                        state_d == pdmc_pkg::ST_DEEP_POWER_DOWN_SELECT || state_d == pdmc_pkg::ST_UP_SRAM;
  wire logic waking = state_d == pdmc_pkg::ST_UP_SRAM || state_d == pdmc_pkg::ST_UP_CORE ||
                      state_d == pdmc_pkg::ST_RELEASE;

  //////////////////////////////////////////////////////////////////////////////
  // mode sequencer

  always_comb begin
    state_d = state_q;
    deepTarget_d = deepTarget_q;
    case (state_q)
      pdmc_pkg::ST_ACTIVE: begin
        if (cpuWfi && !deep_power_down_select) begin
          state_d = pdmc_pkg::ST_SLEEP;
        end else if (cpuWfi) begin
          state_d = pdmc_pkg::ST_DOWN_PERIPH;
          deepTarget_d = !retainAny;
        end else if (lowSpeedRunRequest) begin
          state_d = pdmc_pkg::ST_ACTIVE_LOW;
        end
      end
      pdmc_pkg::ST_ACTIVE_LOW: begin
        if (cpuWfi && !deep_power_down_select) begin
          state_d = pdmc_pkg::ST_SLEEP_LOW;
        end else if (cpuWfi) begin
          state_d = pdmc_pkg::ST_DOWN_PERIPH;
          deepTarget_d = !retainAny;
        end else if (!lowSpeedRunRequest) begin
          state_d = pdmc_pkg::ST_ACTIVE;
        end
      end
      pdmc_pkg::ST_SLEEP: begin
        if (interruptPending) begin
          state_d = pdmc_pkg::ST_ACTIVE;
        end
      end
      pdmc_pkg::ST_SLEEP_LOW: begin
        if (interruptPending) begin
          state_d = pdmc_pkg::ST_ACTIVE_LOW;
        end
      end
      pdmc_pkg::ST_DOWN_PERIPH: begin
        if (settleDone) begin
          state_d = pdmc_pkg::ST_DOWN_CORE;
        end
      end
      pdmc_pkg::ST_DOWN_CORE: begin
        if (settleDone) begin
          state_d = deepTarget_q ? pdmc_pkg::ST_DEEP_POWER_DOWN_SELECT : pdmc_pkg::ST_EXT_SLEEP;
        end
      end
      pdmc_pkg::ST_EXT_SLEEP, pdmc_pkg::ST_DEEP_POWER_DOWN_SELECT: begin
        if (wakeAny) begin
          state_d = pdmc_pkg::ST_UP_SRAM;
        end
      end
      pdmc_pkg::ST_UP_SRAM: begin
        if (settleDone) begin
          state_d = pdmc_pkg::ST_UP_CORE;
        end
      end
      pdmc_pkg::ST_UP_CORE: begin
        if (settleDone) begin
          state_d = pdmc_pkg::ST_RELEASE;
        end
      end
      pdmc_pkg::ST_RELEASE: begin
        state_d = wakeVolt_q ? pdmc_pkg::ST_ACTIVE_LOW : pdmc_pkg::ST_ACTIVE;
      end
      default: begin
        state_d = pdmc_pkg::ST_ACTIVE;
      end
    endcase
  end

  // each sequence step except release waits one settle interval after it is entered
  assign settle_d = (state_d != state_q) ? SETTLE_LOAD : (settleDone ? settle_q : settle_q - 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // domain controls

  always_comb begin
    cpuHigh_d = cpuHigh_q;
    case (state_d)
      pdmc_pkg::ST_ACTIVE, pdmc_pkg::ST_SLEEP: cpuHigh_d = 1'b1;
      pdmc_pkg::ST_ACTIVE_LOW, pdmc_pkg::ST_SLEEP_LOW: cpuHigh_d = 1'b0;
      pdmc_pkg::ST_UP_SRAM, pdmc_pkg::ST_UP_CORE, pdmc_pkg::ST_RELEASE: cpuHigh_d = !wakeVolt_q;
      default: cpuHigh_d = cpuHigh_q;
    endcase
  end

  always_comb begin
    mode_d = mode_q;
    case (state_d)
      pdmc_pkg::ST_ACTIVE: mode_d = pdmc_pkg::MODE_ACTIVE;
      pdmc_pkg::ST_ACTIVE_LOW: mode_d = pdmc_pkg::MODE_ACTIVE_LOW;
      pdmc_pkg::ST_SLEEP: mode_d = pdmc_pkg::MODE_SLEEP;
      pdmc_pkg::ST_SLEEP_LOW: mode_d = pdmc_pkg::MODE_SLEEP_LOW;
      pdmc_pkg::ST_EXT_SLEEP: mode_d = pdmc_pkg::MODE_EXT_SLEEP;
      pdmc_pkg::ST_DEEP_POWER_DOWN_SELECT: mode_d = pdmc_pkg::MODE_DEEP_POWER_DOWN_SELECT;
      default: mode_d = mode_q;
    endcase
  end

  assign cpuOn_d = !coreDown;
  assign hold_d = !runNext && state_d != pdmc_pkg::ST_RELEASE;
  assign gated_d = hold_d || state_d == pdmc_pkg::ST_SLEEP || state_d == pdmc_pkg::ST_SLEEP_LOW;
  assign slowClock_d = state_d == pdmc_pkg::ST_EXT_SLEEP || state_d == pdmc_pkg::ST_DEEP_POWER_DOWN_SELECT;
  assign busy_d = !runNext && !slowClock_d;

  // peripheral and radio power only follow software while the core runs; their voltage requests pass through always
  assign perOn_d = runNext && perPowerRequest;
  assign radioOn_d = runNext && radioPowerRequest;
  assign perHigh_d = perVoltHighRequest;
  assign radioHigh_d = radioVoltHighRequest;

  // sram stays as it was while the peripherals drop, then retained or off
  assign sramOn_d = (runNext || waking) ? sramWanted :
                    (state_d == pdmc_pkg::ST_DOWN_PERIPH ? sramOn_q : '0);
  assign retain_d = enterDownCore ? (sramOn_q & sramRetainRequest) : (keepRetain ? retain_q : '0);
  assign trim_d = (retain_d != '0) ? sramRetentionTrim : pdmc_pkg::TRIM_NOMINAL;

  generate
    for (genvar a = 0; a < ANALOG_COUNT; a++) begin : g_analog
      assign analogOn_d[a] = runNext && analogPowerRequest[a];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // register port and sram decode

  assign wakeVolt_d = (regWrite && regHit) ? regWdata[pdmc_pkg::WAKE_VOLT_BIT] : wakeVolt_q;
  assign regRdata_d = regHit ? {31'h0, wakeVolt_q} : 32'h0;
  assign sramSel_d = sramDecode(memAddr);

  //////////////////////////////////////////////////////////////////////////////
  // flops

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= pdmc_pkg::ST_ACTIVE;
      settle_q <= '0;
      deepTarget_q <= 1'b0;
      wakeVolt_q <= pdmc_pkg::WAKE_VOLT_RESET;
      regRdata_q <= '0;
      sramSel_q <= '0;
      mode_q <= pdmc_pkg::MODE_ACTIVE;
      busy_q <= 1'b0;
    end else if (clockEnable) begin
      state_q <= state_d;
      settle_q <= settle_d;
      deepTarget_q <= deepTarget_d;
      wakeVolt_q <= wakeVolt_d;
      regRdata_q <= regRdata_d;
      sramSel_q <= sramSel_d;
      mode_q <= mode_d;
      busy_q <= busy_d;
    end
  end

  // power on reset: every domain up, core at 1.1V, all sram blocks on
  always_ff @(posedge clock) begin
    if (!resetn) begin
      awoOn_q <= 1'b1;
      slowClock_q <= 1'b0;
      cpuOn_q <= 1'b1;
      cpuHigh_q <= 1'b1;
      gated_q <= 1'b0;
      hold_q <= 1'b0;
      perOn_q <= 1'b1;
      perHigh_q <= 1'b1;
      radioOn_q <= 1'b1;
      radioHigh_q <= 1'b1;
      sramOn_q <= '1;
      retain_q <= '0;
      trim_q <= pdmc_pkg::TRIM_NOMINAL;
      analogOn_q <= '1;
    end else if (clockEnable) begin
      awoOn_q <= 1'b1;
      slowClock_q <= slowClock_d;
      cpuOn_q <= cpuOn_d;
      cpuHigh_q <= cpuHigh_d;
      gated_q <= gated_d;
      hold_q <= hold_d;
      perOn_q <= perOn_d;
      perHigh_q <= perHigh_d;
      radioOn_q <= radioOn_d;
      radioHigh_q <= radioHigh_d;
      sramOn_q <= sramOn_d;
      retain_q <= retain_d;
      trim_q <= trim_d;
      analogOn_q <= analogOn_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign regRdata = regRdata_q;
  assign sramBlockSelect = sramSel_q;
  assign awoPowerOn = awoOn_q;
  assign awoSlowClock = slowClock_q;
  assign cpuPowerOn = cpuOn_q;
  assign cpuVoltHigh = cpuHigh_q;
  assign cpuClockGated = gated_q;
  assign cpuResetHold = hold_q;
  assign perPowerOn = perOn_q;
  assign perVoltHigh = perHigh_q;
  assign radioPowerOn = radioOn_q;
  assign radioVoltHigh = radioHigh_q;
  assign sramPowerOn = sramOn_q;
  assign sramRetain = retain_q;
  assign sramSupplyTrim = trim_q;
  assign analogPowerOn = analogOn_q;
  assign powerMode = mode_q;
  assign sequenceBusy = busy_q;

endmodule : pdmc_power_controller

`default_nettype wire

// >>> hw/pdmc_pkg.sv
// Purpose: shared constants for the power domain mode controller
// Assumes: 40 MHz controller clock
// Notes: addresses are byte addresses on the system map
package pdmc_pkg;

  localparam int DOMAIN_COUNT = 6;
  localparam int SRAM_BLOCKS = 7;
  localparam logic [31:0] SRAM_BASE = 32'h0010_0000;
  localparam logic [31:0] SRAM_END = 32'h0013_3fff;
  localparam int SRAM_BLOCK_SHIFT = 15;
  localparam logic [SRAM_BLOCKS-1:0] SRAM_FIRST_ONLY = 7'h01;

  localparam logic [31:0] WAKE_VOLT_ADDR = 32'h2020_1048;
  localparam int WAKE_VOLT_BIT = 0;
  localparam logic WAKE_VOLT_RESET = 1'h0;

  localparam int TRIM_WIDTH = 4;
  localparam logic [TRIM_WIDTH-1:0] TRIM_NOMINAL = 4'hf;

  localparam int CLOCK_PERIOD_PS = 25000;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int SETTLE_WIDTH = $clog2(SETTLE_CYCLES + 1);

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h0,
    ST_ACTIVE_LOW = 4'h1,
    ST_SLEEP = 4'h2,
    ST_SLEEP_LOW = 4'h3,
    ST_EXT_SLEEP = 4'h4,
    ST_DEEP_POWER_DOWN_SELECT = 4'h5,
    ST_DOWN_PERIPH = 4'h6,
    ST_DOWN_CORE = 4'h7,
    ST_UP_SRAM = 4'h8,
    ST_UP_CORE = 4'h9,
    ST_RELEASE = 4'ha
  } pdmc_state_e;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h0,
    MODE_ACTIVE_LOW = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_SLEEP_LOW = 3'h3,
    MODE_EXT_SLEEP = 3'h4,
    MODE_DEEP_POWER_DOWN_SELECT = 3'h5
  } pdmc_mode_e;

endpackage : pdmc_pkg

// >>> verif/pdmc_cpu_model.sv
// Purpose: cpu core and wake source model for the power controller
// Assumes: drives its lines just after the falling edge of clock
// Notes: irq and wake requests stand until the controller answers or a bound runs out; wfi is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module pdmc_cpu_model (
  input wire logic clock,
  input wire logic cpuClockGated,
  input wire logic cpuResetHold,
  output logic cpuWfi,
  output logic deep_power_down_select,
  output logic interruptPending,
  output logic external_wake_interrupt,
  output logic radio_low_power_counter,
  output logic rtcWakeInterrupt
);
  initial begin
    cpuWfi = 1'h0;
    deep_power_down_select = 1'h0;
    interruptPending = 1'h0;
    {rtcWakeInterrupt, radio_low_power_counter, external_wake_interrupt} = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // only a running core executes the sleep instruction
  task automatic wfi(input logic deep);
    @(negedge clock);
    cpuWfi = !cpuClockGated && !cpuResetHold;
    deep_power_down_select = deep;
    @(negedge clock);
    cpuWfi = 1'h0;
    deep_power_down_select = !deep;
  endtask : wfi
  task automatic irq();
    @(negedge clock);
    interruptPending = 1'h1;
    @(negedge clock);
    for (int n = 0; n < 20 && cpuClockGated; n++) @(negedge clock);
    interruptPending = 1'h0;
  endtask : irq
  // source 0 external, 1 radio counter, 2 rtc; held until the core is released
  task automatic wake(input int src);
    @(negedge clock);
    {rtcWakeInterrupt, radio_low_power_counter, external_wake_interrupt} = 3'h1 << src;
    @(negedge clock);
    for (int n = 0; n < 60 && cpuResetHold; n++) @(negedge clock);
    {rtcWakeInterrupt, radio_low_power_counter, external_wake_interrupt} = 3'h0;
  endtask : wake
endmodule : pdmc_cpu_model
`default_nettype wire

// >>> verif/pdmc_checker.sv
// Purpose: port checker for the power controller
// Assumes: one clock domain, synchronous active low reset
// Notes: bound to every controller instance
`timescale 1ns/1ps
`default_nettype none
module pdmc_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEnable,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regRdata,
  input wire logic cpuWfi,
  input wire logic deep_power_down_select,
  input wire logic interruptPending,
  input wire logic lowSpeedRunRequest,
  input wire logic [31:0] memAddr,
  input wire logic [6:0] sramBlockSelect,
  input wire logic awoPowerOn,
  input wire logic awoSlowClock,
  input wire logic cpuPowerOn,
  input wire logic cpuVoltHigh,
  input wire logic cpuClockGated,
  input wire logic cpuResetHold,
  input wire logic perPowerOn,
  input wire logic radioPowerOn,
  input wire logic [6:0] sramPowerOn,
  input wire logic [6:0] sramRetain,
  input wire logic [2:0] powerMode,
  input wire logic sequenceBusy
);
  logic [6:0] selExp;
  assign selExp = (memAddr >= pdmc_pkg::SRAM_BASE && memAddr <= pdmc_pkg::SRAM_END) ?
    7'h01 << ((memAddr - pdmc_pkg::SRAM_BASE) >> pdmc_pkg::SRAM_BLOCK_SHIFT) : 7'h00;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_awo_never_off: assert property (awoPowerOn) else $error("awo off");
  a_core_off_deps: assert property (!cpuPowerOn |-> !perPowerOn && !radioPowerOn) else $error("dep");
  a_shallow_entry: assert property (clockEnable && cpuWfi && !deep_power_down_select && !sequenceBusy
    && powerMode == 3'h0 && !lowSpeedRunRequest && !cpuClockGated
    |=> powerMode == 3'h2 && cpuClockGated && cpuPowerOn) else $error("shallow");
  a_irq_ends_sleep: assert property (clockEnable && interruptPending && !sequenceBusy
    && powerMode inside {3'h2, 3'h3} |=> !cpuClockGated && powerMode == $past(powerMode) - 3'h2)
    else $error("irq");
  a_deep_entry: assert property (clockEnable && cpuWfi && deep_power_down_select && !sequenceBusy
    && powerMode inside {3'h0, 3'h1} |=> sequenceBusy && cpuResetHold && !perPowerOn && !radioPowerOn)
    else $error("deep");
  a_slow_when_down: assert property (!sequenceBusy && powerMode >= 3'h4
    |-> awoSlowClock && !cpuPowerOn) else $error("slow");
  a_deep_all_off: assert property (!sequenceBusy && powerMode == 3'h5
    |-> sramPowerOn == 7'h00 && sramRetain == 7'h00) else $error("deep sram");
  a_ext_retained: assert property (!sequenceBusy && powerMode == 3'h4 |-> sramRetain != 7'h00)
    else $error("ext sram");
  a_wake_release: assert property ($fell(sequenceBusy) && powerMode <= 3'h1
    |-> cpuPowerOn && !cpuResetHold && !cpuClockGated && !awoSlowClock) else $error("release");
  a_mode_voltage: assert property (!sequenceBusy && $stable(powerMode) && powerMode == $past(powerMode, 2)
    && powerMode <= 3'h3 |-> cpuVoltHigh == (powerMode inside {3'h0, 3'h2})) else $error("volt");
  a_sram_decode: assert property (clockEnable |=> sramBlockSelect == $past(selExp)) else $error("dec");
  a_reg_unmapped: assert property (clockEnable && regAddr != pdmc_pkg::WAKE_VOLT_ADDR
    |=> regRdata == 32'h0) else $error("unmapped");
  c_ext: cover property (powerMode == 3'h4 && !sequenceBusy);
  c_deep: cover property (powerMode == 3'h5 && !sequenceBusy);
  c_sleep_low: cover property (powerMode == 3'h3);
endmodule : pdmc_checker
bind pdmc_power_controller pdmc_checker chk (.*);
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: self-checking bench for the power controller
// Assumes: settle count shortened to 2 cycles
// Notes: inputs change on the falling edge of clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] VA = pdmc_pkg::WAKE_VOLT_ADDR;
  logic clock = 1'h0;
  logic resetn, clockEnable, regWrite, lowSpeedRunRequest, perPowerRequest, perVoltHighRequest;
  logic radioPowerRequest, radioVoltHighRequest, awoPowerOn, awoSlowClock, cpuPowerOn, cpuVoltHigh;
  logic cpuWfi, deep_power_down_select, interruptPending, external_wake_interrupt;
  logic radio_low_power_counter, rtcWakeInterrupt, cpuClockGated, cpuResetHold;
  logic perPowerOn, perVoltHigh, radioPowerOn, radioVoltHigh, sequenceBusy;
  logic [31:0] regAddr, regWdata, regRdata, memAddr;
  logic [6:0] sramPowerRequest, sramRetainRequest, sramBlockSelect, sramPowerOn, sramRetain;
  logic [3:0] sramRetentionTrim, sramSupplyTrim;
  logic [7:0] analogPowerRequest, analogPowerOn;
  logic [2:0] powerMode;
  int n_fail = 0;
  int n_compared = 0;
  always #12.5 clock = ~clock;
  pdmc_power_controller #(.SETTLE_COUNT(2)) dut (.*);
  pdmc_cpu_model cpu (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clock);
    regWrite = 1'h1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'h0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(negedge clock);
    regAddr = a;
    @(negedge clock);
    chk("regRdata", exp, regRdata);
  endtask : rd
  task automatic dec(input logic [31:0] a, input logic [31:0] exp);
    @(negedge clock);
    memAddr = a;
    @(negedge clock);
    chk("sramBlockSelect", exp, sramBlockSelect);
  endtask : dec
  task automatic settle();
    int n;
    for (n = 0; n < 100 && sequenceBusy !== 1'h0; n++) @(negedge clock);
    if (n == 100) begin
      n_fail++;
      end_sim();
    end
    @(negedge clock);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'h0;
    clockEnable = 1'h1;
    {regWrite, regAddr, regWdata, memAddr, lowSpeedRunRequest} = '0;
    {perPowerRequest, perVoltHighRequest, radioPowerRequest, radioVoltHighRequest} = 4'hf;
    sramPowerRequest = 7'h7f;
    sramRetainRequest = 7'h00;
    sramRetentionTrim = 4'h3;
    analogPowerRequest = 8'hff;
    repeat (12) @(negedge clock);
    chk("powerMode", 32'h0, powerMode);
    chk("cpuVoltHigh", 32'h1, cpuVoltHigh);
    chk("sramSupplyTrim", 32'hf, sramSupplyTrim);
    chk("awoPowerOn", 32'h1, awoPowerOn);
    resetn = 1'h1;
    rd(VA, 32'h0);
    wr(VA, 32'h1);
    rd(VA, 32'h1);
    wr(VA + 32'h4, 32'h0);
    rd(VA + 32'h4, 32'h0);
    rd(VA, 32'h1);
    wr(VA, 32'hffff_fffe);
    rd(VA, 32'h0);
    for (int i = 0; i < 7; i++) begin
      dec(pdmc_pkg::SRAM_BASE + (32'(i) << pdmc_pkg::SRAM_BLOCK_SHIFT), 32'h1 << i);
      dec(pdmc_pkg::SRAM_BASE + (32'(i) << pdmc_pkg::SRAM_BLOCK_SHIFT) + 32'h3fff, 32'h1 << i);
    end
    dec(pdmc_pkg::SRAM_BASE + 32'h7fff, 32'h1);
    dec(pdmc_pkg::SRAM_END + 32'h1, 32'h0);
    dec(pdmc_pkg::SRAM_BASE - 32'h1, 32'h0);
    perPowerRequest = 1'h0;
    perVoltHighRequest = 1'h0;
    radioVoltHighRequest = 1'h0;
    sramPowerRequest = 7'h05;
    analogPowerRequest = 8'ha5;
    repeat (2) @(negedge clock);
    chk("perPowerOn", 32'h0, perPowerOn);
    chk("radioPowerOn", 32'h1, radioPowerOn);
    chk("radioVoltHigh", 32'h0, radioVoltHigh);
    chk("perVoltHigh", 32'h0, perVoltHigh);
    chk("sramPowerOn", 32'h05, sramPowerOn);
    chk("analogPowerOn", 32'ha5, analogPowerOn);
    sramPowerRequest = 7'h00;
    repeat (2) @(negedge clock);
    chk("sramPowerOn", 32'h01, sramPowerOn);
    {perPowerRequest, perVoltHighRequest, radioVoltHighRequest, sramPowerRequest, analogPowerRequest} = '1;
    cpu.wfi(1'h0);
    chk("powerMode", 32'h2, powerMode);
    chk("cpuClockGated", 32'h1, cpuClockGated);
    chk("cpuPowerOn", 32'h1, cpuPowerOn);
    chk("perPowerOn", 32'h1, perPowerOn);
    cpu.irq();
    chk("powerMode", 32'h0, powerMode);
    clockEnable = 1'h0;
    lowSpeedRunRequest = 1'h1;
    repeat (3) @(negedge clock);
    chk("powerMode", 32'h0, powerMode);
    clockEnable = 1'h1;
    repeat (2) @(negedge clock);
    chk("powerMode", 32'h1, powerMode);
    chk("cpuVoltHigh", 32'h0, cpuVoltHigh);
    cpu.wfi(1'h0);
    chk("powerMode", 32'h3, powerMode);
    cpu.irq();
    chk("powerMode", 32'h1, powerMode);
    // source s wakes; odd s selects low voltage and leaves no block retained
    for (int s = 0; s < 3; s++) begin
      wr(VA, 32'(s % 2));
      lowSpeedRunRequest = 1'(s % 2);
      sramRetainRequest = (s == 1) ? 7'h00 : 7'h06;
      cpu.wfi(1'h1);
      settle();
      chk("powerMode", (s == 1) ? 32'h5 : 32'h4, powerMode);
      chk("awoSlowClock", 32'h1, awoSlowClock);
      chk("perPowerOn", 32'h0, perPowerOn);
      chk("cpuPowerOn", 32'h0, cpuPowerOn);
      chk("analogPowerOn", 32'h0, analogPowerOn);
      chk("cpuResetHold", 32'h1, cpuResetHold);
      chk("sramRetain", (s == 1) ? 32'h0 : 32'h6, sramRetain);
      if (s != 1) chk("sramSupplyTrim", 32'h3, sramSupplyTrim);
      cpu.irq();
      chk("powerMode", (s == 1) ? 32'h5 : 32'h4, powerMode);
      cpu.wake(s);
      settle();
      chk("powerMode", 32'(s % 2), powerMode);
      chk("cpuVoltHigh", 32'(1 - s % 2), cpuVoltHigh);
      chk("cpuPowerOn", 32'h1, cpuPowerOn);
      chk("sramPowerOn", 32'h7f, sramPowerOn);
      chk("perPowerOn", 32'h1, perPowerOn);
      chk("perVoltHigh", 32'h1, perVoltHigh);
      chk("cpuResetHold", 32'h0, cpuResetHold);
    end
    // reset in the middle of a power-down sequence
    wr(VA, 32'h1);
    cpu.wfi(1'h1);
    resetn = 1'h0;
    repeat (2) @(negedge clock);
    resetn = 1'h1;
    chk("sequenceBusy", 32'h0, sequenceBusy);
    chk("cpuResetHold", 32'h0, cpuResetHold);
    chk("perPowerOn", 32'h1, perPowerOn);
    chk("powerMode", 32'h0, powerMode);
    rd(VA, 32'h0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
